/* hw/add_pkg.sv */
// Package for the converter digital self-diagnostics block
package add_pkg;

   // Register addresses
   localparam logic [5:0] ADDR_SAFETY_EN   = 6'h21;
   localparam logic [5:0] ADDR_FAULT_FLAGS = 6'h22;
   localparam logic [5:0] ADDR_MUX_FIRST   = 6'h28;
   localparam logic [5:0] ADDR_MUX_LAST    = 6'h2b;
   localparam logic [5:0] ADDR_SAFE_TALLY  = 6'h2d;
   localparam logic [5:0] ADDR_OVS_TALLY   = 6'h2e;

   // Safety-enable field positions
   localparam int EN_WRITE_CHK  = 3;
   localparam int EN_READ_CHK   = 4;
   localparam int EN_WATCHDOG   = 5;
   localparam int EN_TALLY      = 6;
   localparam int EN_IFACE_CHK  = 7;

   // Fault-flag field positions
   localparam int FLG_WRITE_ERR = 3;
   localparam int FLG_READ_ERR  = 4;
   localparam int FLG_STUCK     = 5;

   // Reset values
   localparam logic [7:0] SAFETY_EN_RST = 8'h00;
   localparam logic [7:0] MUX_RST       = 8'h00;

   // Mux select codes
   localparam logic [2:0] MUX_NORMAL = 3'h0;
   localparam int         MUX_W      = 3;
   localparam int         MUX_HI_LSB = 4;

   // Timing
   localparam int CLK_MHZ          = 125;
   localparam int SAFE_CLK_MHZ     = 16;
   localparam int CONV_LIMIT_NS    = 4000;
   localparam int CONV_LIMIT_TICKS = (CONV_LIMIT_NS * SAFE_CLK_MHZ) / 1000;
   localparam logic [5:0] TALLY_DIV_LAST = 6'h3f;

   // Interface-check patterns, channel 1 first
   localparam logic [15:0] IFACE_PAT [8] = '{
      16'hacca, 16'h5cc5, 16'ha33a, 16'h5335,
      16'hcaac, 16'hc55c, 16'h3aa3, 16'h3553 };

   // Register access request
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [5:0] addr;
      logic [7:0] wdata;
   } add_req_type;

endpackage

/* hw/add_diag.sv */
// Digital self-diagnostics: interface check, access checks, watchdog, tallies
// Behaviour
// - Interface-check bit forces all eight results
// - Forced patterns fixed per channel one..eight
// - Enabled invalid read sets read-error flag
// - Read checking only while its enable set
// - Read flag holds until overwritten or disabled
// - Bad-address or read-only write sets write flag
// - Write checking only while its enable set
// - Write flag holds until overwritten or disabled
// - Watchdog times conversions on independent clock
// - Over 4 us: partial reset, stuck flag
// - Stuck flag cleared only by writing one
// - Each internal oversampled conversion timed separately
// - Two internal 16 MHz clocks exist
// - Tallies count only while tally enable set
// - Tally increments once per 64 clock cycles
// - Safety tally 0x2d, oversample tally 0x2e
// - Internal node selected disconnects external input
// - Mux settings programmed through channel_diag_select to 0x2b
// - Three-bit code picks one of eight nodes
// - Summary digital-error bit follows any monitor
`timescale 1ns/1ps
module add_diag
   import add_pkg::*;
(
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        reset_n_i,
   // Internal clock ticks, one-cycle enables
   input  wire logic        safety_clock_i,
   input  wire logic        oversample_clock_i,
   // Register access from the serial or parallel interface
   input  wire add_req_type req_i,
   output logic [7:0]       rdata_o,
   output logic             rd_unmapped_o,
   // Conversion path
   input  wire logic        conv_active_i,
   input  wire logic [15:0] conv_result_i [8],
   output logic [15:0]      result_o [8],
   output logic             partial_reset_o,
   // Diagnostic mux control, code and external-input connect
   output logic [2:0]       mux_sel_o [8],
   output logic [7:0]       input_connect_o,
   // Summary error
   output logic             digital_error_o
);

   // Registers
   logic [7:0]  safety_en_r, safety_en_nxt;   // Safety enables
   logic [5:0]  flags_r, flags_nxt;           // Fault flags 5..3 used
   logic [7:0]  mux_r [4];                    // Mux select pairs
   logic [7:0]  mux_nxt [4];
   logic [7:0]  safe_tally_r, safe_tally_nxt; // Safety clock tally
   logic [7:0]  ovs_tally_r, ovs_tally_nxt;   // Oversample clock tally
   logic [5:0]  safe_div_r, safe_div_nxt;     // Divide-by-64 prescalers
   logic [5:0]  ovs_div_r, ovs_div_nxt;
   logic [7:0]  wd_cnt_r, wd_cnt_nxt;         // Watchdog tick counter
   logic        wd_fire_r, wd_fire_nxt;       // Partial reset pulse
   logic [7:0]  rdata_r, rdata_nxt;
   logic        unm_r, unm_nxt;
   logic [15:0] result_r [8];
   logic [15:0] result_nxt [8];

   // Address classes
   function automatic logic is_mux(input logic [5:0] a);
      is_mux = (a >= ADDR_MUX_FIRST) && (a <= ADDR_MUX_LAST);
   endfunction

   function automatic logic is_mapped(input logic [5:0] a);
      is_mapped = (a == ADDR_SAFETY_EN) || (a == ADDR_FAULT_FLAGS) ||
                  is_mux(a) || (a == ADDR_SAFE_TALLY) ||
                  (a == ADDR_OVS_TALLY);
   endfunction

   function automatic logic is_ro(input logic [5:0] a);
      is_ro = (a == ADDR_SAFE_TALLY) || (a == ADDR_OVS_TALLY);
   endfunction

   logic bad_rd, bad_wr, wd_over;
   logic [1:0] mux_idx;

   // Next-state logic for registers and monitors
   always_comb begin
      safety_en_nxt  = safety_en_r;
      flags_nxt      = flags_r;
      mux_nxt        = mux_r;
      safe_tally_nxt = safe_tally_r;
      ovs_tally_nxt  = ovs_tally_r;
      safe_div_nxt   = safe_div_r;
      ovs_div_nxt    = ovs_div_r;
      wd_cnt_nxt     = wd_cnt_r;
      wd_fire_nxt    = 1'b0;
      rdata_nxt      = rdata_r;
      unm_nxt        = 1'b0;
      mux_idx        = 2'(req_i.addr - ADDR_MUX_FIRST);
      bad_rd = req_i.rd && !is_mapped(req_i.addr);
      bad_wr = req_i.wr &&
               (!is_mapped(req_i.addr) || is_ro(req_i.addr));
      // Software writes; clears come first so a same-cycle event wins
      if (req_i.wr) begin
         case (req_i.addr)
            ADDR_SAFETY_EN: safety_en_nxt = req_i.wdata;
            ADDR_FAULT_FLAGS:
               flags_nxt = flags_r & ~req_i.wdata[5:0];
            default: begin
               if (is_mux(req_i.addr))
                  mux_nxt[mux_idx] = req_i.wdata;
            end
         endcase
      end
      // Disabling a checker drops its flag
      if (!safety_en_nxt[EN_READ_CHK])
         flags_nxt[FLG_READ_ERR] = 1'b0;
      if (!safety_en_nxt[EN_WRITE_CHK])
         flags_nxt[FLG_WRITE_ERR] = 1'b0;
      // Access checks, gated by their enables
      if (bad_rd && safety_en_r[EN_READ_CHK])
         flags_nxt[FLG_READ_ERR] = 1'b1;
      if (bad_wr && safety_en_r[EN_WRITE_CHK])
         flags_nxt[FLG_WRITE_ERR] = 1'b1;
      // Watchdog counts safety-clock ticks, never the system clock.
      // Busy per internal conversion, so oversampling restarts it.
      wd_over = 1'b0;
      if (!conv_active_i || !safety_en_r[EN_WATCHDOG]) begin
         wd_cnt_nxt = '0;
      end else if (safety_clock_i) begin
         if (wd_cnt_r >= 8'(CONV_LIMIT_TICKS)) begin
            wd_over    = 1'b1;
            wd_cnt_nxt = '0;
         end else begin
            wd_cnt_nxt = wd_cnt_r + 8'h01;
         end
      end
      if (wd_over) begin
         wd_fire_nxt       = 1'b1;
         flags_nxt[FLG_STUCK] = 1'b1;
      end
      // Clock tallies: prescale by 64 then count
      if (safety_en_r[EN_TALLY]) begin
         if (safety_clock_i) begin
            safe_div_nxt = safe_div_r + 6'h01;
            if (safe_div_r == TALLY_DIV_LAST)
               safe_tally_nxt = safe_tally_r + 8'h01;
         end
         if (oversample_clock_i) begin
            ovs_div_nxt = ovs_div_r + 6'h01;
            if (ovs_div_r == TALLY_DIV_LAST)
               ovs_tally_nxt = ovs_tally_r + 8'h01;
         end
      end
      // Read data, registered
      if (req_i.rd) begin
         case (req_i.addr)
            ADDR_SAFETY_EN:   rdata_nxt = safety_en_r;
            ADDR_FAULT_FLAGS: rdata_nxt = {2'b00, flags_r};
            ADDR_SAFE_TALLY:  rdata_nxt = safe_tally_r;
            ADDR_OVS_TALLY:   rdata_nxt = ovs_tally_r;
            default: begin
               rdata_nxt = is_mux(req_i.addr) ? mux_r[mux_idx] : 8'h00;
            end
         endcase
         unm_nxt = bad_rd;
      end
   end

   // Result selection: patterns replace samples in check mode
   always_comb begin
      for (int c = 0; c < 8; c++) begin
         result_nxt[c] = safety_en_r[EN_IFACE_CHK] ? IFACE_PAT[c]
                                                   : conv_result_i[c];
      end
   end

   // State registers
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         safety_en_r  <= SAFETY_EN_RST;
         flags_r      <= '0;
         for (int i = 0; i < 4; i++) mux_r[i] <= MUX_RST;
         for (int c = 0; c < 8; c++) result_r[c] <= '0;
         safe_tally_r <= '0;
         ovs_tally_r  <= '0;
         safe_div_r   <= '0;
         ovs_div_r    <= '0;
         wd_cnt_r     <= '0;
         wd_fire_r    <= 1'b0;
         rdata_r      <= '0;
         unm_r        <= 1'b0;
      end else begin
         safety_en_r  <= safety_en_nxt;
         flags_r      <= flags_nxt;
         mux_r        <= mux_nxt;
         result_r     <= result_nxt;
         safe_tally_r <= safe_tally_nxt;
         ovs_tally_r  <= ovs_tally_nxt;
         safe_div_r   <= safe_div_nxt;
         ovs_div_r    <= ovs_div_nxt;
         wd_cnt_r     <= wd_cnt_nxt;
         wd_fire_r    <= wd_fire_nxt;
         rdata_r      <= rdata_nxt;
         unm_r        <= unm_nxt;
      end
   end

   // Mux decode: channel pairs, lower channel in low bits
   always_comb begin
      for (int c = 0; c < 8; c++) begin
         mux_sel_o[c] = (c % 2 == 0) ? mux_r[c/2][MUX_W-1:0]
                        : mux_r[c/2][MUX_HI_LSB +: MUX_W];
         input_connect_o[c] = (mux_sel_o[c] == MUX_NORMAL);
      end
   end

   // Outputs
   assign result_o        = result_r;
   assign rdata_o         = rdata_r;
   assign rd_unmapped_o   = unm_r;
   assign partial_reset_o = wd_fire_r;
   assign digital_error_o = |flags_r[FLG_STUCK:FLG_WRITE_ERR];

   // Assertions
   property p_iface;
      @(posedge clock_i) disable iff (!reset_n_i)
      safety_en_r[EN_IFACE_CHK] |=> result_o[0] == 16'hacca &&
                                    result_o[7] == 16'h3553;
   endproperty
   a_iface: assert property (p_iface) else $error("pattern wrong");

   property p_rd_err;
      @(posedge clock_i) disable iff (!reset_n_i)
      bad_rd && safety_en_r[EN_READ_CHK] |=> flags_r[FLG_READ_ERR];
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("no read flag");

   property p_rd_gate;
      @(posedge clock_i) disable iff (!reset_n_i)
      !safety_en_r[EN_READ_CHK] |=> !flags_r[FLG_READ_ERR];
   endproperty
   a_rd_gate: assert property (p_rd_gate) else $error("read gate");

   // Only a register write may drop the read flag
   property p_rd_hold;
      @(posedge clock_i) disable iff (!reset_n_i)
      flags_r[FLG_READ_ERR] && !req_i.wr |=> flags_r[FLG_READ_ERR];
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read lost");

   property p_wr_err;
      @(posedge clock_i) disable iff (!reset_n_i)
      bad_wr && safety_en_r[EN_WRITE_CHK] |=> flags_r[FLG_WRITE_ERR];
   endproperty
   a_wr_err: assert property (p_wr_err) else $error("no write flag");

   // Checker off: the write flag never rises
   property p_wr_gate;
      @(posedge clock_i) disable iff (!reset_n_i)
      !safety_en_r[EN_WRITE_CHK] |=> !flags_r[FLG_WRITE_ERR];
   endproperty
   a_wr_gate: assert property (p_wr_gate) else $error("write gate");

   // Only a register write may drop the write flag
   property p_wr_hold;
      @(posedge clock_i) disable iff (!reset_n_i)
      flags_r[FLG_WRITE_ERR] && !req_i.wr |=> flags_r[FLG_WRITE_ERR];
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write lost");

   property p_stuck_hold;
      @(posedge clock_i) disable iff (!reset_n_i)
      flags_r[FLG_STUCK] && !(req_i.wr && req_i.addr == ADDR_FAULT_FLAGS)
      |=> flags_r[FLG_STUCK];
   endproperty
   a_stuck_hold: assert property (p_stuck_hold) else $error("hold");

   sequence s_fire;
      wd_over ##1 partial_reset_o;
   endsequence
   property p_wd;
      @(posedge clock_i) disable iff (!reset_n_i)
      wd_over |-> s_fire ##0 flags_r[FLG_STUCK];
   endproperty
   a_wd: assert property (p_wd) else $error("watchdog action");

   property p_tally_stop;
      @(posedge clock_i) disable iff (!reset_n_i)
      !safety_en_r[EN_TALLY] |=> $stable(safe_tally_r);
   endproperty
   a_tally_stop: assert property (p_tally_stop) else $error("tally");

   property p_ovs_stop;
      @(posedge clock_i) disable iff (!reset_n_i)
      !safety_en_r[EN_TALLY] |=> $stable(ovs_tally_r);
   endproperty
   a_ovs_stop: assert property (p_ovs_stop) else $error("ovs ran");

   // Last prescaler tick of 64 bumps the tally by one
   property p_tally_step;
      @(posedge clock_i) disable iff (!reset_n_i)
      safety_en_r[EN_TALLY] && safety_clock_i &&
      safe_div_r == TALLY_DIV_LAST
      |=> safe_tally_r == $past(safe_tally_r) + 8'h01;
   endproperty
   a_tally_step: assert property (p_tally_step) else $error("step");

   // Checked against the register, not the decoded code
   property p_connect;
      @(posedge clock_i) disable iff (!reset_n_i)
      input_connect_o[0] == (mux_r[0][MUX_W-1:0] == MUX_NORMAL);
   endproperty
   a_connect: assert property (p_connect) else $error("connected");

   // Channel eight sits in the high code of the last register
   property p_connect_hi;
      @(posedge clock_i) disable iff (!reset_n_i)
      input_connect_o[7] == (mux_r[3][MUX_HI_LSB +: MUX_W] == MUX_NORMAL);
   endproperty
   a_connect_hi: assert property (p_connect_hi) else $error("ch8");

   property p_sum;
      @(posedge clock_i) disable iff (!reset_n_i)
      flags_r[FLG_STUCK] || flags_r[FLG_READ_ERR] ||
      flags_r[FLG_WRITE_ERR] |-> digital_error_o;
   endproperty
   a_sum: assert property (p_sum) else $error("summary missing");

endmodule

/* dv/add_host.sv */
// Host controller model issuing register reads and writes
`timescale 1ns/1ps
module add_host
   import add_pkg::*;
(
   // Clock
   input  wire logic       clock_i,
   // Register access toward the device
   output add_req_type     req_o,
   input  wire logic [7:0] rdata_i,
   input  wire logic       rd_unmapped_i
);
   // Idle bus from time zero
   initial begin
      req_o = '0;
   end

   // One write pulse, launched after the falling edge
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      @(negedge clock_i);
      req_o = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
      @(negedge clock_i);
      req_o = '0;
   endtask

   // One read; answer taken in the cycle after the taking edge
   task automatic rd(input logic [5:0] a, output logic [7:0] v,
                     output logic un);
      @(negedge clock_i);
      req_o = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(negedge clock_i);
      req_o = '0;
      v = rdata_i;
      un = rd_unmapped_i;
   endtask
endmodule

/* dv/add_diag_tb.sv */
// Self-checking bench for the digital self-diagnostics block
`timescale 1ns/1ps
module add_diag_tb import add_pkg::*; ;
   logic        clock_i = 1'b0;        // System clock
   logic        reset_n_i = 1'b0;      // Async reset
   logic        safe_tick = 1'b0;      // Safety clock tick
   logic        ovs_tick = 1'b0;       // Oversample clock tick
   logic        conv_on = 1'b0;        // Conversion in progress
   logic [15:0] raw [8];               // Raw converter results
   logic [15:0] res [8];               // Results seen
   logic [2:0]  msel [8];              // Mux codes seen
   add_req_type req;                   // Host request
   logic [7:0]  rdata, d, sb, conn, ec;
   logic        unm, u, prst, derr;
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          n_prst = 0;
   int          seed, ns;

   add_diag dut_u (
      .clock_i            (clock_i),
      .reset_n_i          (reset_n_i),
      .safety_clock_i     (safe_tick),
      .oversample_clock_i (ovs_tick),
      .req_i              (req),
      .rdata_o            (rdata),
      .rd_unmapped_o      (unm),
      .conv_active_i      (conv_on),
      .conv_result_i      (raw),
      .result_o           (res),
      .partial_reset_o    (prst),
      .mux_sel_o          (msel),
      .input_connect_o    (conn),
      .digital_error_o    (derr)
   );
   add_host host_u (.clock_i(clock_i), .req_o(req), .rdata_i(rdata),
                    .rd_unmapped_i(unm));

   // 8 ns clock
   always #4 clock_i = ~clock_i;

   // Hang guard and partial-reset pulse tally
   always @(posedge clock_i) begin
      cyc++;
      if (prst === 1'b1) n_prst++;
      if (cyc == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end

   // Verdict and end of run
   task automatic stop_test();
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Byte-wide compare
   task automatic chk8(input string nm, input logic [7:0] e, g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Result-word compare
   task automatic chk16(input string nm, input logic [15:0] e, g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Register read and compare
   task automatic rchk(input logic [5:0] a, input logic [7:0] e,
                       input string nm);
      host_u.rd(a, d, u);
      chk8(nm, e, d);
   endtask

   // Ticks spaced 8 cycles, close to a 16 MHz rate
   task automatic tick(input int n, input logic os);
      repeat (n) begin
         @(negedge clock_i);
         if (os) ovs_tick = 1'b1;
         else safe_tick = 1'b1;
         @(negedge clock_i);
         ovs_tick = 1'b0;
         safe_tick = 1'b0;
         repeat (6) @(negedge clock_i);
      end
   endtask

   // Forced pattern or raw value per channel
   function automatic logic [15:0] exp_res(input int ch, input logic ifc);
      logic [15:0] pat [8] = '{16'hacca, 16'h5cc5, 16'ha33a, 16'h5335,
                               16'hcaac, 16'hc55c, 16'h3aa3, 16'h3553};
      return ifc ? pat[ch] : raw[ch];
   endfunction

   // One count per 64 ticks, remainder dropped
   function automatic logic [7:0] exp_tally(input int n);
      return 8'(n / 64);
   endfunction

   initial begin
      foreach (raw[i]) raw[i] = 16'h0000;
      seed = $urandom(42736);
      repeat (8) @(negedge clock_i);
      reset_n_i = 1'b1;
      rchk(ADDR_SAFETY_EN, 8'h00, "enable rst");
      chk8("connect rst", 8'hff, conn);
      // Patterns on, then raw data back
      for (int k = 0; k < 2; k++) begin
         foreach (raw[i]) raw[i] = 16'($urandom);
         host_u.wr(ADDR_SAFETY_EN, (k == 0) ? 8'h80 : 8'h00);
         @(negedge clock_i);
         foreach (res[i])
            chk16("result", exp_res(i, k == 0), res[i]);
      end
      // Unmapped reads, checker off then on
      host_u.rd(6'h3f, d, u);
      rchk(ADDR_FAULT_FLAGS, 8'h00, "rd off");
      host_u.wr(ADDR_SAFETY_EN, 8'h10);
      host_u.rd(6'h2c, d, u);
      chk8("unmapped", 8'h01, {7'h0, u});
      chk8("derr", 8'h01, {7'h0, derr});
      rchk(ADDR_FAULT_FLAGS, 8'h10, "rd on");
      host_u.wr(ADDR_FAULT_FLAGS, 8'h10);
      rchk(ADDR_FAULT_FLAGS, 8'h00, "rd clr");
      // Write to read-only, then disable, then unmapped while off
      host_u.wr(ADDR_SAFETY_EN, 8'h08);
      host_u.wr(ADDR_SAFE_TALLY, 8'h55);
      rchk(ADDR_FAULT_FLAGS, 8'h08, "wr ro");
      host_u.wr(ADDR_SAFETY_EN, 8'h00);
      rchk(ADDR_FAULT_FLAGS, 8'h00, "wr dis");
      host_u.wr(6'h30, 8'h01);
      rchk(ADDR_FAULT_FLAGS, 8'h00, "wr off");
      // Mux codes, corner 0 and 7 first; range taken as widest already
      for (int r = 0; r < 4; r++) begin
         sb = (r == 0) ? 8'h70 : (8'($urandom) & 8'h77);
         host_u.wr(6'(ADDR_MUX_FIRST + r), sb);
         rchk(6'(ADDR_MUX_FIRST + r), sb, "mux rd");
         chk8("sel lo", {5'h0, sb[2:0]}, {5'h0, msel[2*r]});
         chk8("sel hi", 8'(sb[6:4]), 8'(msel[2*r+1]));
         ec[2*r] = (sb[2:0] == 3'h0);
         ec[2*r+1] = (sb[6:4] == 3'h0);
      end
      chk8("connect", ec, conn);
      // Watchdog: a gap restarts timing, 65th tick times out
      host_u.wr(ADDR_SAFETY_EN, 8'h20);
      conv_on = 1'b1;
      tick(40, 1'b0);
      conv_on = 1'b0;
      @(negedge clock_i);
      conv_on = 1'b1;
      tick(64, 1'b0);
      chk8("no timeout", 8'h00, 8'(n_prst));
      tick(1, 1'b0);
      conv_on = 1'b0;
      chk8("timeout", 8'h01, 8'(n_prst));
      host_u.wr(ADDR_SAFETY_EN, 8'h00);
      rchk(ADDR_FAULT_FLAGS, 8'h20, "stuck");
      chk8("derr", 8'h01, {7'h0, derr});
      host_u.wr(ADDR_FAULT_FLAGS, 8'h00);
      rchk(ADDR_FAULT_FLAGS, 8'h20, "stuck hold");
      host_u.wr(ADDR_FAULT_FLAGS, 8'h20);
      rchk(ADDR_FAULT_FLAGS, 8'h00, "stuck clr");
      // Safety tally idle while off, then both count
      rchk(ADDR_SAFE_TALLY, 8'h00, "tally off");
      host_u.wr(ADDR_SAFETY_EN, 8'h40);
      ns = $urandom_range(100, 400);
      tick(ns, 1'b0);
      tick(255, 1'b1);
      rchk(ADDR_SAFE_TALLY, exp_tally(ns), "safe tally");
      rchk(ADDR_OVS_TALLY, exp_tally(255), "ovs tally");
      stop_test();
   end
endmodule
